// file: rtl/brw_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - long press runs the selected action
// - action code 1x means ship mode
// - action fires the cycle after the timer expires
// - warn flag and interrupt before expiry
// - warning interval is software programmable
// - switching to power cycle mid-press ignored
// - power cycle needs input whole press
// - software bit starts power cycle, aon on
// - silent host after adapter forces cycle
// - watchdog off after reset until enabled
// - interrupt pin silent unless startup valid
// - interrupt drives low for 128 us
// - masked trigger produces no pulse
// - unmasking with condition present gives nothing
// - termination sets done, pauses, resumes charging
// - loop flags interrupt, reduce current, double timer
// - button flags stay until host reads
module brw_ctrl (
  input  wire logic                           core_clk,
  input  wire logic                           resetn,
  input  wire logic                           clk_en,
  input  wire logic                           push_button_input,
  input  wire logic [1:0]                     long_press_action_sel,
  input  wire logic [brw_pkg::TMR_W-1:0]      long_press_time,
  input  wire logic [brw_pkg::TMR_W-1:0]      reset_warning_interval,
  input  wire logic                           reset_requires_input,
  input  wire logic                           adapter_input_supply,
  input  wire logic                           software_power_cycle_request,
  input  wire logic                           silent_host_watchdog_enable,
  input  wire logic                           i2c_transaction_seen,
  input  wire logic                           startup_valid,
  input  wire logic                           flag_read,
  input  wire logic [brw_pkg::NUM_SRC-1:0]    src_mask,
  input  wire logic                           charge_term_status,
  input  wire logic                           constant_voltage_status,
  input  wire logic                           input_current_limit_status,
  input  wire logic                           power_path_loop_status,
  input  wire logic                           input_voltage_loop_status,
  input  wire logic                           thermal_foldback_status,
  input  wire logic                           ce_toggle,
  input  wire logic                           recharge_threshold,
  input  wire logic                           timer_double_en,
  output logic                                int_n_out,
  output logic                                int_n_oe,
  output logic                                power_cycle_pulse,
  output logic                                ship_mode_pulse,
  output logic                                always_on_rail_en,
  output logic                                system_output_rail_off,
  output logic                                reset_warning_flag,
  output logic [brw_pkg::NUM_SRC-1:0]         event_flags,
  output logic                                charge_paused,
  output logic                                safety_timer_clear,
  output logic                                reduced_current,
  output logic                                safety_timer_double
);
  import brw_pkg::*;

  brw_btn_t                 state;
  logic [TMR_W-1:0]         press_cnt;
  logic [TMR_W-1:0]         lat_time;
  logic [TMR_W-1:0]         lat_warn;
  logic                     lat_cycle_ok;
  logic                     vin_whole;
  logic [TMR_W-1:0]         wd_cnt;
  logic                     wd_armed;
  logic                     adapter_q;
  logic [NUM_SRC-1:0]       status_q;
  logic [NUM_SRC-1:0]       trig;
  logic [PULSE_W-1:0]       pulse_cnt;
  logic                     pulse_req;
  logic                     warn_hit;
  logic                     expire_hit;
  logic                     wd_fire;
  logic                     term_q;
  logic [NUM_SRC-1:0]       status_now;
  logic [PULSE_W-1:0]       oe_run;

  assign status_now = {thermal_foldback_status, input_voltage_loop_status,
                       power_path_loop_status, input_current_limit_status,
                       constant_voltage_status, charge_term_status, 1'b0};

  // warning point and expiry point of the current press
  assign warn_hit   = (state == BRW_PRESS) && (press_cnt + lat_warn >= lat_time);
  assign expire_hit = (state != BRW_IDLE) && (state != BRW_HOLD)
                    && (press_cnt >= lat_time);

  // button press sequencer; timings latched at press start
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state        <= BRW_IDLE;
      press_cnt    <= '0;
      lat_time     <= '0;
      lat_warn     <= '0;
      lat_cycle_ok <= 1'b0;
      vin_whole    <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        BRW_IDLE: begin
          press_cnt <= '0;
          if (!push_button_input) begin
            state        <= BRW_PRESS;
            press_cnt    <= TMR_W'(1);
            lat_time     <= long_press_time;
            lat_warn     <= reset_warning_interval;
            lat_cycle_ok <= (long_press_action_sel == ACT_POWER_CYCLE);
            vin_whole    <= adapter_input_supply;
          end
        end
        BRW_PRESS, BRW_WARNED: begin
          if (push_button_input) begin
            state     <= BRW_IDLE;
            press_cnt <= '0;
          end else begin
            press_cnt <= press_cnt + TMR_W'(1);
            vin_whole <= vin_whole & adapter_input_supply;
            if (expire_hit) begin
              state <= BRW_HOLD;
            end else if (warn_hit) begin
              state <= BRW_WARNED;
            end
          end
        end
        BRW_HOLD: begin
          if (push_button_input) begin
            state <= BRW_IDLE;
          end
        end
      endcase
    end
  end

  // watchdog counting from adapter attach until host speaks
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wd_cnt    <= '0;
      wd_armed  <= 1'b0;
      adapter_q <= 1'b0;
    end else if (clk_en) begin
      adapter_q <= adapter_input_supply;
      if (!silent_host_watchdog_enable || !adapter_input_supply
          || i2c_transaction_seen) begin
        wd_armed <= 1'b0;
        wd_cnt   <= '0;
      end else if (adapter_input_supply && !adapter_q) begin
        wd_armed <= 1'b1;
        wd_cnt   <= '0;
      end else if (wd_armed) begin
        if (wd_cnt == TMR_W'(WDOG_CYC - 1)) begin
          wd_armed <= 1'b0;
        end
        wd_cnt <= wd_cnt + TMR_W'(1);
      end
    end
  end
  assign wd_fire = wd_armed && (wd_cnt == TMR_W'(WDOG_CYC - 1))
                 && silent_host_watchdog_enable && adapter_input_supply
                 && !i2c_transaction_seen;

  // power actions taken on expiry, software request or watchdog
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      power_cycle_pulse      <= 1'b0;
      ship_mode_pulse        <= 1'b0;
      always_on_rail_en      <= 1'b1;
      system_output_rail_off <= 1'b0;
    end else if (clk_en) begin
      power_cycle_pulse <= 1'b0;
      ship_mode_pulse   <= 1'b0;
      always_on_rail_en <= 1'b1;
      system_output_rail_off <= 1'b0;
      if (expire_hit && !push_button_input) begin
        if (long_press_action_sel[ACT_SHIP_BIT]) begin
          ship_mode_pulse        <= 1'b1;
          system_output_rail_off <= 1'b1;
        end else if (long_press_action_sel == ACT_POWER_CYCLE && lat_cycle_ok
                     && (!reset_requires_input || (vin_whole && adapter_input_supply))) begin
          power_cycle_pulse      <= 1'b1;
          system_output_rail_off <= 1'b1;
        end
      end
      if (software_power_cycle_request || wd_fire) begin
        power_cycle_pulse      <= 1'b1;
        system_output_rail_off <= 1'b1;
      end
    end
  end

  // rising-edge triggers, gated by mask
  always_comb begin
    trig = status_now & ~status_q & ~src_mask;
    trig[SRC_WARN] = warn_hit && !push_button_input && !src_mask[SRC_WARN]
                   && !event_flags[SRC_WARN];
  end

  // sticky flags; set wins over the host read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_q    <= '0;
      event_flags <= '0;
    end else if (clk_en) begin
      status_q <= status_now;
      event_flags <= (flag_read ? '0 : event_flags) | (status_now & ~status_q);
      if (warn_hit && !push_button_input) begin
        event_flags[SRC_WARN] <= 1'b1;
      end
    end
  end
  // open-drain interrupt pulse generator
  assign pulse_req = |trig && startup_valid;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pulse_cnt <= '0;
      int_n_oe  <= 1'b0;
      int_n_out <= 1'b0;
    end else if (clk_en) begin
      int_n_out <= 1'b0;
      if (!startup_valid) begin
        pulse_cnt <= '0;
        int_n_oe  <= 1'b0;
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - PULSE_W'(1);
        int_n_oe  <= (pulse_cnt != PULSE_W'(1));
      end else if (pulse_req) begin
        pulse_cnt <= PULSE_W'(INT_PULSE_CYC);
        int_n_oe  <= 1'b1;
      end
    end
  end

  // charger responses to termination and regulation loops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      term_q              <= 1'b0;
      charge_paused       <= 1'b0;
      safety_timer_clear  <= 1'b0;
      reduced_current     <= 1'b0;
      safety_timer_double <= 1'b0;
      reset_warning_flag  <= 1'b0;
    end else if (clk_en) begin
      term_q             <= charge_term_status;
      safety_timer_clear <= 1'b0;
      reset_warning_flag <= event_flags[SRC_WARN];
      if (charge_term_status && !term_q) begin
        charge_paused <= 1'b1;
      end else if (charge_paused && (ce_toggle || recharge_threshold
                   || (adapter_input_supply != adapter_q))) begin
        charge_paused      <= 1'b0;
        safety_timer_clear <= 1'b1;
      end
      reduced_current     <= |(status_now & LOOP_MASK);
      safety_timer_double <= timer_double_en && |(status_now & LOOP_MASK);
    end
  end

  // running length of the interrupt pulse, for the length check
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      oe_run <= '0;
    end else if (clk_en) begin
      oe_run <= int_n_oe ? oe_run + PULSE_W'(1) : '0;
    end
  end

  // interrupt pulse stays driven for at least 8 cycles
  AST_PULSE_LEN: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && startup_valid && $rose(int_n_oe)) |-> int_n_oe [*8])
    else $error("interrupt pulse too short");
  AST_NO_INT_FAULT: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !startup_valid) |=> !int_n_oe)
    else $error("interrupt while startup invalid");
  AST_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && push_button_input && state == BRW_PRESS) |=> state == BRW_IDLE)
    else $error("release did not clear press");
  AST_WD_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !silent_host_watchdog_enable) |=> !wd_armed)
    else $error("watchdog fired while disabled");
  AST_AON: assert property (@(posedge core_clk) disable iff (!resetn)
    power_cycle_pulse |-> always_on_rail_en)
    else $error("always-on rail dropped");
  AST_SW_CYCLE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && software_power_cycle_request) |=> power_cycle_pulse)
    else $error("software cycle not started");
  AST_MASKED: assert property (@(posedge core_clk) disable iff (!resetn)
    (&src_mask) |-> !pulse_req)
    else $error("masked source requested pulse");
  AST_SHIP: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && expire_hit && !push_button_input && long_press_action_sel[ACT_SHIP_BIT]
     && !software_power_cycle_request && !wd_fire)
    |=> ship_mode_pulse && !power_cycle_pulse)
    else $error("ship action not taken");
  AST_VIN_GATE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && expire_hit && reset_requires_input && !vin_whole
     && !software_power_cycle_request && !wd_fire) |=> !power_cycle_pulse)
    else $error("cycle without input supply");

  // full pulse length and edge-only triggering
  AST_PULSE_FULL: assert property (@(posedge core_clk) disable iff (!resetn)
    ($fell(int_n_oe) && $past(startup_valid)) |-> oe_run == PULSE_W'(INT_PULSE_CYC))
    else $error("interrupt pulse length wrong");
  AST_NO_FALL_INT: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && (status_now & ~status_q) == '0 && !trig[SRC_WARN] && !int_n_oe)
    |=> !int_n_oe)
    else $error("interrupt without a rising edge");
  AST_UNMASK_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && $fell(src_mask[SRC_ILIM]) && status_now[SRC_ILIM] && status_q[SRC_ILIM])
    |-> !trig[SRC_ILIM])
    else $error("unmasking raised a trigger");

  // long-press sequencer checks
  AST_EXPIRE_NOW: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && expire_hit && !push_button_input && long_press_action_sel == ACT_POWER_CYCLE
     && lat_cycle_ok && !reset_requires_input) |=> power_cycle_pulse)
    else $error("power cycle late at expiry");
  AST_LATE_CYCLE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && expire_hit && !lat_cycle_ok && !software_power_cycle_request && !wd_fire)
    |=> !power_cycle_pulse)
    else $error("mid-press switch to power cycle honoured");
  AST_WARN_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && warn_hit && !push_button_input) |=> event_flags[SRC_WARN])
    else $error("warning flag not set");
  AST_WARN_EARLY: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && expire_hit && !push_button_input) |-> (state == BRW_WARNED || warn_hit))
    else $error("expiry without warning");
  AST_RELEASE_WARNED: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && push_button_input && state == BRW_WARNED)
    |=> (state == BRW_IDLE && press_cnt == '0))
    else $error("release after warning kept the press");
  AST_NO_EARLY_ACT: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && push_button_input && !software_power_cycle_request && !wd_fire)
    |=> !power_cycle_pulse && !ship_mode_pulse)
    else $error("action without a held button");

  // watchdog and charger response checks
  AST_WD_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && i2c_transaction_seen) |=> !wd_armed)
    else $error("watchdog still armed after host transaction");
  AST_PAUSE: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && charge_term_status && !term_q) |=> charge_paused)
    else $error("termination did not pause charging");
  AST_LOOP_SLOW: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && |(status_now & LOOP_MASK)) |=> reduced_current)
    else $error("regulation loop did not reduce current");
  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !flag_read && event_flags[SRC_DONE]) |=> event_flags[SRC_DONE])
    else $error("done flag dropped before host read");
endmodule : brw_ctrl

// file: rtl/brw_pkg.sv
package brw_pkg;
  // clock rate and pulse timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned INT_PULSE_US    = 128;
  localparam int unsigned INT_PULSE_CYC   = (INT_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WDOG_TIME_S     = 14;
  localparam int unsigned WDOG_CYC        = WDOG_TIME_S * CLK_HZ;
  localparam int unsigned TMR_W           = 32;
  localparam int unsigned PULSE_W         = 11;
  // long-press action encodings
  localparam logic [1:0]  ACT_POWER_CYCLE = 2'h0;
  localparam logic [1:0]  ACT_NONE        = 2'h1;
  localparam int unsigned ACT_SHIP_BIT    = 1;
  // event source indices
  localparam int unsigned NUM_SRC         = 7;
  localparam int unsigned SRC_WARN        = 0;
  localparam int unsigned SRC_DONE        = 1;
  localparam int unsigned SRC_CV          = 2;
  localparam int unsigned SRC_ILIM        = 3;
  localparam int unsigned SRC_DPPM        = 4;
  localparam int unsigned SRC_VDPM        = 5;
  localparam int unsigned SRC_THRM        = 6;
  localparam logic [NUM_SRC-1:0] LOOP_MASK = 7'h78;
  // button sequencer states, gray along the press path
  typedef enum logic [1:0] {
    BRW_IDLE  = 2'b00,
    BRW_PRESS = 2'b01,
    BRW_WARNED = 2'b11,
    BRW_HOLD  = 2'b10
  } brw_btn_t;
endpackage : brw_pkg

// file: verification/brw_host_model.sv
`timescale 1ns/10ps
// host side: watches the open-drain interrupt line and reads flags back
module brw_host_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic int_n_out,
  input  wire logic int_n_oe,
  input  wire logic auto_read,
  input  wire logic read_req,
  output logic      flag_read,
  output logic      i2c_transaction_seen,
  output int        pulse_count,
  output int        last_width
);
  logic int_line;
  logic int_d;
  logic req_d;
  logic rd;
  int   width;
  // pull-up holds the line high unless the device drives it
  assign int_line = int_n_oe ? int_n_out : 1'b1;
  // a flag read is also a bus transaction seen by the device
  assign rd = (read_req && !req_d) || (auto_read && !int_d && int_line);
  // count and time low pulses, read flags when a pulse ends
  always @(posedge core_clk) begin
    if (!resetn) begin
      int_d <= 1'b1;
      req_d <= 1'b0;
      width <= 0;
      flag_read <= 1'b0;
      i2c_transaction_seen <= 1'b0;
      pulse_count <= 0;
      last_width <= 0;
    end else begin
      int_d <= int_line;
      req_d <= read_req;
      if (!int_line) width <= width + 1;
      if (int_d && !int_line) pulse_count <= pulse_count + 1;
      if (!int_d && int_line) begin
        last_width <= width;
        width <= 0;
      end
      flag_read <= rd;
      i2c_transaction_seen <= rd;
    end
  end
endmodule : brw_host_model

// file: verification/button_reset_watchdog_irq_test.sv
`timescale 1ns/10ps
module button_reset_watchdog_irq_test;
  import brw_pkg::*;
  logic core_clk, resetn, push_button_input, reset_requires_input, adapter_input_supply;
  logic software_power_cycle_request, startup_valid, flag_read, recharge_threshold;
  logic i2c_transaction_seen, auto_read, read_req, int_n_out, int_n_oe, power_cycle_pulse;
  logic ship_mode_pulse, always_on_rail_en, system_output_rail_off, reset_warning_flag;
  logic charge_paused, safety_timer_clear, reduced_current, safety_timer_double;
  logic [1:0]         long_press_action_sel;
  logic [TMR_W-1:0]   long_press_time, reset_warning_interval;
  logic [NUM_SRC-1:0] src_mask, st, event_flags;
  int pulse_count, last_width, fails, checks_done, cyc_n, pc_cnt, sm_cnt, evt_t, t0, h0, p0, s0;
  int row_src[7] = '{1, 2, 3, 4, 5, 6, 3};
  bit row_msk[7] = '{0, 0, 0, 0, 0, 0, 1};
  int row_pls[7] = '{1, 1, 1, 1, 1, 1, 0};

  brw_ctrl u_dut (.core_clk, .resetn, .clk_en(1'b1), .push_button_input,
    .long_press_action_sel, .long_press_time, .reset_warning_interval,
    .reset_requires_input, .adapter_input_supply, .software_power_cycle_request,
    .silent_host_watchdog_enable(1'b0), .i2c_transaction_seen, .startup_valid, .flag_read,
    .src_mask, .charge_term_status(st[1]), .constant_voltage_status(st[2]),
    .input_current_limit_status(st[3]), .power_path_loop_status(st[4]),
    .input_voltage_loop_status(st[5]), .thermal_foldback_status(st[6]), .ce_toggle(1'b0),
    .recharge_threshold, .timer_double_en(1'b1), .int_n_out, .int_n_oe, .power_cycle_pulse,
    .ship_mode_pulse, .always_on_rail_en, .system_output_rail_off, .reset_warning_flag,
    .event_flags, .charge_paused, .safety_timer_clear, .reduced_current, .safety_timer_double);
  brw_host_model u_host (.core_clk, .resetn, .int_n_out, .int_n_oe, .auto_read, .read_req,
    .flag_read, .i2c_transaction_seen, .pulse_count, .last_width);

  // clock and cycle bookkeeping, hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (power_cycle_pulse === 1'b1) begin
      pc_cnt <= pc_cnt + 1;
      evt_t <= cyc_n;
    end
    if (ship_mode_pulse === 1'b1) begin
      sm_cnt <= sm_cnt + 1;
      evt_t <= cyc_n;
    end
    if (resetn === 1'b1 && always_on_rail_en !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t exp=1 got=%h", $time, always_on_rail_en);
    end
    if (resetn === 1'b1
        && system_output_rail_off !== (power_cycle_pulse | ship_mode_pulse)) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, power_cycle_pulse | ship_mode_pulse,
               system_output_rail_off);
    end
    if (cyc_n == 40000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // hold the button, optionally switch the action or drop the input at cycle 5
  task automatic press(input logic [1:0] a1, input logic [1:0] a2, input logic drop,
                       input int hold, input int epc, input int esm, input int ewarn);
    p0 = pc_cnt;
    t0 = sm_cnt;
    h0 = pulse_count;
    long_press_action_sel = a1;
    push_button_input = 1'b0;
    s0 = cyc_n;
    cyc(5);
    long_press_action_sel = a2;
    if (drop) adapter_input_supply = 1'b0;
    cyc(hold - 5);
    chk(ewarn != 0, reset_warning_flag);
    push_button_input = 1'b1;
    adapter_input_supply = 1'b1;
    cyc(1400);
    chk(epc, pc_cnt - p0);
    chk(esm, sm_cnt - t0);
    chk(ewarn, pulse_count - h0);
  endtask : press

  initial begin
    core_clk = 0; resetn = 0; push_button_input = 1; reset_requires_input = 0;
    adapter_input_supply = 1; software_power_cycle_request = 0; startup_valid = 1;
    recharge_threshold = 0; auto_read = 0; read_req = 0; src_mask = '0; st = '0;
    long_press_action_sel = 2'h1; long_press_time = 32'h28; reset_warning_interval = 32'ha;
    cyc_n = 0; pc_cnt = 0; sm_cnt = 0; fails = 0; checks_done = 0;
    cyc(6);
    chk(0, int_n_oe);
    chk(1, always_on_rail_en);
    chk(0, event_flags);
    resetn = 1;
    $display("reset test done");
    // one status source per row, the last one masked
    for (int i = 0; i < 7; i++) begin
      h0 = pulse_count;
      src_mask = NUM_SRC'(row_msk[i]) << row_src[i];
      st[row_src[i]] = 1'b1;
      cyc(4);
      if (row_src[i] >= 3) chk(2'h3, {reduced_current, safety_timer_double});
      if (row_src[i] == 1) chk(1, charge_paused);
      cyc(1400);
      chk(row_pls[i], pulse_count - h0);
      chk(0, int_n_out);
      if (!row_msk[i]) chk(INT_PULSE_CYC, last_width);
      if (!row_msk[i]) chk(1, event_flags[row_src[i]]);
      st = '0;
      read_req = 1'b1;
      cyc(2);
      read_req = 1'b0;
      chk(0, event_flags);
      recharge_threshold = 1'b1;
      cyc(1);
      chk(row_src[i] == 1, safety_timer_clear);
      recharge_threshold = 1'b0;
      cyc(2);
      chk(0, charge_paused);
    end
    $display("status rows done");
    auto_read = 1'b1;
    press(2'h0, 2'h0, 0, 45, 1, 0, 1);
    chk(1, (evt_t - s0 >= 38) && (evt_t - s0 <= 42));
    press(2'h2, 2'h2, 0, 45, 0, 1, 1);
    press(2'h3, 2'h3, 0, 45, 0, 1, 1);
    press(2'h1, 2'h1, 0, 45, 0, 0, 1);
    press(2'h1, 2'h0, 0, 45, 0, 0, 1);
    press(2'h0, 2'h1, 0, 45, 0, 0, 1);
    reset_requires_input = 1'b1;
    press(2'h0, 2'h0, 1, 45, 0, 0, 1);
    reset_requires_input = 1'b0;
    press(2'h0, 2'h0, 0, 20, 0, 0, 0);
    reset_warning_interval = 32'h1e;
    press(2'h0, 2'h0, 0, 15, 0, 0, 1);
    reset_warning_interval = 32'ha;
    p0 = pc_cnt;
    software_power_cycle_request = 1'b1;
    cyc(1);
    software_power_cycle_request = 1'b0;
    cyc(3);
    chk(1, pc_cnt - p0);
    $display("long press tests done");
    h0 = pulse_count;
    src_mask = 7'h08;
    st[3] = 1'b1;
    cyc(5);
    src_mask = '0;
    cyc(1400);
    chk(0, pulse_count - h0);
    st[3] = 1'b0;
    cyc(1400);
    chk(0, pulse_count - h0);
    startup_valid = 1'b0;
    st[2] = 1'b1;
    cyc(1400);
    chk(0, pulse_count - h0);
    $display("interrupt gating done");
    results();
  end
endmodule : button_reset_watchdog_irq_test
